//--- common/ulpam_if.sv
// Shared ULPI bus between the transceiver end and the Link end
`timescale 1ns/1ps
`default_nettype none
interface ulpam_if;
  logic [7:0] linkDo;
  logic [7:0] linkOe;
  logic [7:0] phyDo;
  logic [7:0] phyOe;
  logic [7:0] bus;
  logic       dir;
  logic       stp;
  logic       resetPinN;

  // Undriven bits read low: each bit takes the enabled end's data, else 0
  assign bus = (phyOe & phyDo) | (~phyOe & linkOe & linkDo);

  modport phy (input bus, input stp, input resetPinN, output phyDo, output phyOe, output dir);
  modport link (input bus, input dir, output linkDo, output linkOe, output stp, output resetPinN);
endinterface : ulpam_if
`default_nettype wire

//--- common/ulpam_pkg.sv
// Shared constants and types for the alternate-mode ULPI bus ends
// What this block does
// - 3-pin: gate bit0 sends bit1 data, bit2 zero-state
// - 3-pin gate low: device drives receive, zero-low, 7:4 low
// - 6-pin: bits 0-2 Link-driven, sent only while gated
// - 6-pin: bits 4-6 receive levels, bit 7 low
// - Bit 3 carries active-high interrupt in alternate modes
// - Accessory entry stops clock unless keep-running set
// - Accessory mode interrupts only from enabled sources
// - Capture sources before DIR, flag on difference
// - No line-state reported during accessory mode
// - Accessory bit0 goes to minus line when enabled
// - Accessory bit1 carries plus line when enabled
// - Accessory bit2 low or input; bits 7:4 low
// - Exit: STP, DIR drops, resume after STP drops
// - Reset pin pulse restores synchronous mode
// - UART enables written before accessory mode bit
// - UART example: 49@04, 00@39, 0C@19, 04@07
// - UART entry switches regulator and applies pull-ups
// - UART edge rates follow transceiver select
// - Audio switches follow enables right after write
// - Audio example: 48@04, 30@19, 04@07
// - Mode write, five cycles, DIR, clock stop, format
package ulpam_pkg;
  localparam int        NSRC          = 4;
  localparam [5:0]      REG_FUNC      = 6'h04;
  localparam [5:0]      REG_IFC       = 6'h07;
  localparam [5:0]      REG_ACC       = 6'h19;
  localparam [5:0]      REG_INTEN     = 6'h1d;
  localparam [5:0]      REG_IOPWR     = 6'h39;
  localparam [7:0]      FUNC_RST      = 8'h41;
  localparam [7:0]      IFC_RST       = 8'h00;
  localparam [7:0]      ACC_RST       = 8'h00;
  localparam [7:0]      INTEN_RST     = 8'h00;
  localparam [7:0]      IOPWR_RST     = 8'h00;
  localparam int        IFC_SER6      = 0;
  localparam int        IFC_SER3      = 1;
  localparam int        IFC_ACC       = 2;
  localparam int        IFC_KEEP      = 3;
  localparam int        ACC_TXD       = 2;
  localparam int        ACC_RXD       = 3;
  localparam int        ACC_LEFT      = 4;
  localparam int        ACC_RIGHT     = 5;
  localparam int        ACC_B2DIR     = 6;
  localparam int        FUNC_XCVR     = 0;
  localparam int        FUNC_OPM      = 3;
  localparam int        IOPWR_UREG    = 0;
  localparam [1:0]      CMD_WRITE     = 2'h2;
  localparam int        CLK_NS        = 10;
  localparam int        ENTRY_NS      = 50;
  localparam int        ENTRY_CYC     = (ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int        RSTP_NS       = 40;
  localparam int        RSTP_CYC      = (RSTP_NS + CLK_NS - 1) / CLK_NS;
  localparam [3:0]      SW_ADDR       = 4'h0;
  localparam [3:0]      SW_DATA       = 4'h1;
  localparam [3:0]      SW_CTL        = 4'h2;
  localparam [3:0]      SW_STAT       = 4'h3;
  localparam [3:0]      SW_BUS        = 4'h4;
  localparam int        CTL_EXIT      = 0;
  localparam int        CTL_RST       = 1;
  localparam int        CTL_GATE      = 2;
  localparam int        CTL_TXD       = 3;
  localparam int        CTL_TXZ       = 4;
  localparam int        CTL_UART      = 5;
  localparam int        CTL_B2OE      = 6;

  typedef enum logic [3:0] {
    PS_SYNC  = 4'b0001,
    PS_ENTER = 4'b0010,
    PS_ALT   = 4'b0100,
    PS_EXIT  = 4'b1000
  } ulpam_phy_e;

  typedef enum logic [3:0] {
    LS_IDLE = 4'b0001,
    LS_CMD  = 4'b0010,
    LS_DATA = 4'b0100,
    LS_STP  = 4'b1000
  } ulpam_link_e;

  // Mode priority when more than one mode bit is set
  function automatic logic [2:0] ulpam_mode(input logic [7:0] ifc);
    ulpam_mode[IFC_SER6] = ifc[IFC_SER6];
    ulpam_mode[IFC_SER3] = ifc[IFC_SER3] & ~ifc[IFC_SER6];
    ulpam_mode[IFC_ACC]  = ifc[IFC_ACC] & ~ifc[IFC_SER3] & ~ifc[IFC_SER6];
  endfunction : ulpam_mode
endpackage : ulpam_pkg

//--- core/ulpam_link_end.sv
// Link end: software port, register write sequencer, alternate-mode drive and exit
`timescale 1ns/1ps
`default_nettype none
module ulpam_link_end (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  ulpam_if.link           ulpi,
  input  wire logic [3:0] swAddr,
  input  wire logic [7:0] swWdata,
  input  wire logic       swWr,
  input  wire logic       swRd,
  output logic      [7:0] swRdata
);
  import ulpam_pkg::*;

  logic [5:0]  addrReg;
  logic [7:0]  dataReg;
  logic [7:0]  ctl;
  logic [7:0]  shadowIfc;
  logic        dirQ;
  logic        exitStp;
  logic        seqStp;
  logic [3:0]  rstCnt;
  ulpam_link_e seq;
  logic [7:0]  seqByte;

  wire       wrAddr   = swWr & (swAddr == SW_ADDR);
  wire       wrData   = swWr & (swAddr == SW_DATA);
  wire       wrCtl    = swWr & (swAddr == SW_CTL);
  wire       busy     = (seq != LS_IDLE);
  wire       start    = wrData & ~busy & ~ulpi.dir;
  wire [2:0] mode     = ulpam_mode(shadowIfc);
  wire [7:0] gated3   = ctl[CTL_GATE] ? 8'h07 : 8'h01;
  wire [7:0] ser6Oe   = 8'h07;
  wire [7:0] accOe    = {5'h00, ctl[CTL_B2OE], 1'b0, 1'b1};
  wire [7:0] serDo    = {5'h00, ctl[CTL_TXZ], ctl[CTL_TXD], ctl[CTL_GATE]};
  wire [7:0] accDo    = {5'h00, ctl[CTL_TXZ], 1'b0, ctl[CTL_UART]};
  wire [7:0] altOe    = mode[IFC_SER6] ? ser6Oe : (mode[IFC_SER3] ? gated3 : accOe);
  wire [7:0] altDo    = mode[IFC_ACC] ? accDo : serDo;
  wire       syncDrv  = ~ulpi.dir & ~dirQ;
  wire       altDrv   = ulpi.dir & dirQ & ~exitStp;
  wire [7:0] next_oe  = syncDrv ? 8'hff : (altDrv ? altOe : 8'h00);
  wire [7:0] next_do  = syncDrv ? seqByte : (altDrv ? altDo : 8'h00);
  wire [7:0] statWord = {4'h0, seqStp | busy, exitStp, ~ulpi.resetPinN, ulpi.dir};
  wire [7:0] next_rd  = ~swRd ? 8'h00 :
                        (swAddr == SW_ADDR) ? {2'h0, addrReg} :
                        (swAddr == SW_DATA) ? dataReg :
                        (swAddr == SW_CTL)  ? ctl :
                        (swAddr == SW_STAT) ? statWord :
                        (swAddr == SW_BUS)  ? ulpi.bus : 8'h00;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addrReg <= 6'h00;
      dataReg <= 8'h00;
      ctl     <= 8'h00;
      swRdata <= 8'h00;
      dirQ    <= 1'b0;
      exitStp <= 1'b0;
      rstCnt  <= 4'h0;
      ulpi.resetPinN <= 1'b1;
    end
    else if (ce)
    begin
      swRdata <= next_rd;
      dirQ    <= ulpi.dir;
      if (wrAddr)
        addrReg <= swWdata[5:0];
      if (start)
        dataReg <= swWdata;
      if (wrCtl)
        ctl <= swWdata & 8'hfc;
      // Hold STP until DIR falls, then release it
      if (exitStp)
        exitStp <= ulpi.dir;
      else
        exitStp <= wrCtl & swWdata[CTL_EXIT] & ulpi.dir;
      if (wrCtl && swWdata[CTL_RST])
        rstCnt <= 4'(RSTP_CYC);
      else if (rstCnt != 4'h0)
        rstCnt <= rstCnt - 4'h1;
      ulpi.resetPinN <= ~((wrCtl & swWdata[CTL_RST]) | (rstCnt > 4'h1));
    end
  end

  // Register write: command byte, data byte, then STP
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seq       <= LS_IDLE;
      seqByte   <= 8'h00;
      seqStp    <= 1'b0;
      shadowIfc <= IFC_RST;
      ulpi.stp  <= 1'b1;
      ulpi.linkDo <= 8'h00;
      ulpi.linkOe <= 8'h00;
    end
    else if (ce)
    begin
      ulpi.linkDo <= next_do;
      ulpi.linkOe <= next_oe;
      ulpi.stp    <= seqStp | exitStp;
      if (wrCtl && swWdata[CTL_RST])
        shadowIfc <= IFC_RST;
      else if (seq == LS_DATA && addrReg == REG_IFC)
        shadowIfc <= dataReg;
      else if (exitStp && !ulpi.dir)
        shadowIfc[IFC_ACC:IFC_SER6] <= 3'h0;
      unique case (seq)
        LS_IDLE:
        begin
          seqStp <= 1'b0;
          if (start)
          begin
            seq     <= LS_CMD;
            seqByte <= {CMD_WRITE, addrReg};
          end
        end
        LS_CMD:
        begin
          seq     <= LS_DATA;
          seqByte <= dataReg;
        end
        LS_DATA:
        begin
          seq     <= LS_STP;
          seqByte <= 8'h00;
          seqStp  <= 1'b1;
        end
        LS_STP:
        begin
          seq    <= LS_IDLE;
          seqStp <= 1'b0;
        end
      endcase
    end
  end
endmodule : ulpam_link_end
`default_nettype wire

//--- core/ulpam_phy_end.sv
// Transceiver end: register writes, mode entry, alternate bus formats and exit
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ulpam_phy_end (
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic                       ce,
  ulpam_if.phy                            ulpi,
  input  wire logic                       rxDiff,
  input  wire logic                       receivePlusLevel,
  input  wire logic                       receiveMinusLevel,
  input  wire logic                       rxZero,
  input  wire logic [ulpam_pkg::NSRC-1:0] intSrc,
  output logic                            lineTxEn,
  output logic                            lineTxData,
  output logic                            singleEndedZeroLine,
  output logic                            uartMinus,
  output logic                            regUart,
  output logic                            pullupsOn,
  output logic                            audioLeft,
  output logic                            audioRight,
  output logic                            ulpiClockRun,
  output logic [1:0]                      edgeSelect,
  output logic [1:0]                      operating_mode_field,
  output logic [1:0]                      regLevel
);
  import ulpam_pkg::*;

  localparam int NS = NSRC + 5;

  logic [NS-1:0]   meta;
  logic [NS-1:0]   syncd;
  logic [7:0]      funcCtl;
  logic [7:0]      ifcCtl;
  logic [7:0]      accCtl;
  logic [7:0]      intEn;
  logic [7:0]      ioPwr;
  logic            cmdPending;
  logic [5:0]      cmdAddr;
  ulpam_phy_e      state;
  logic [3:0]      cnt;
  logic [2:0]      modeQ;
  logic [NSRC-1:0] capt;

  wire [NS-1:0]   rawIn    = {intSrc, ulpi.resetPinN, rxZero, receiveMinusLevel, receivePlusLevel, rxDiff};
  wire            rxDiffS  = syncd[0];
  wire            rxPlusS  = syncd[1];
  wire            rxMinusS = syncd[2];
  wire            rxZeroS  = syncd[3];
  wire            pinRstN  = syncd[4];
  wire [NSRC-1:0] srcLive  = syncd[NS-1:5];

  wire            inSync   = (state == PS_SYNC);
  wire            inAlt    = (state == PS_ALT);
  wire            cmdSeen  = inSync & ~cmdPending & (ulpi.bus[7:6] == CMD_WRITE);
  wire            wrFire   = inSync & cmdPending;
  wire            wrFunc   = wrFire & (cmdAddr == REG_FUNC);
  wire            wrIfc    = wrFire & (cmdAddr == REG_IFC);
  wire            wrAcc    = wrFire & (cmdAddr == REG_ACC);
  wire            wrIntEn  = wrFire & (cmdAddr == REG_INTEN);
  wire            wrIoPwr  = wrFire & (cmdAddr == REG_IOPWR);
  wire [2:0]      modeReq  = ulpam_mode(ifcCtl);
  wire            entryEnd = (cnt == 4'(ENTRY_CYC - 1));
  wire            exitReq  = inAlt & ulpi.stp;
  wire            gate     = ulpi.bus[0];
  wire            ser6     = modeQ[IFC_SER6];
  wire            ser3     = modeQ[IFC_SER3];
  wire            accMode  = modeQ[IFC_ACC];
  wire            uartOn   = accCtl[ACC_TXD] | accCtl[ACC_RXD];

  // Interrupt when an enabled live source differs from its captured value
  wire [NSRC-1:0] srcDiff  = (srcLive ^ capt) & intEn[NSRC-1:0];
  wire            intLine  = |srcDiff;

  // Alternate bus formats; none carries line-state in accessory mode
  wire [7:0]      ser3Do   = {4'h0, intLine, ~rxZeroS, rxDiffS, 1'b0};
  wire [7:0]      ser3Oe   = {4'hf, 1'b1, ~gate, ~gate, 1'b0};
  wire [7:0]      ser6Do   = {1'b0, rxDiffS, rxMinusS, rxPlusS, intLine, 3'h0};
  wire [7:0]      ser6Oe   = 8'hf8;
  wire            rxdBit   = accCtl[ACC_RXD] & rxPlusS;
  wire [7:0]      accDo    = {4'h0, intLine, 1'b0, rxdBit, 1'b0};
  wire [7:0]      accOe    = {4'hf, 1'b1, ~accCtl[ACC_B2DIR], 1'b1, 1'b0};

  wire [7:0]      altDo    = ser6 ? ser6Do : (ser3 ? ser3Do : accDo);
  wire [7:0]      altOe    = ser6 ? ser6Oe : (ser3 ? ser3Oe : accOe);
  wire [7:0]      next_do  = inAlt ? altDo : 8'h00;
  wire [7:0]      next_oe  = (inAlt & ~exitReq & pinRstN) ? altOe : 8'h00;
  // Transmit only once the device has let go of bits 1 and 2, so its own receive levels never reach the line
  wire            txGate   = inAlt & (ser3 | ser6) & gate & ~ulpi.phyOe[1];

  // Input synchroniser
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta  <= '0;
      syncd <= '0;
    end
    else if (ce)
    begin
      meta  <= rawIn;
      syncd <= meta;
    end
  end

  // Register writes from the Link
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmdPending <= 1'b0;
      cmdAddr    <= 6'h00;
      funcCtl    <= FUNC_RST;
      ifcCtl     <= IFC_RST;
      accCtl     <= ACC_RST;
      intEn      <= INTEN_RST;
      ioPwr      <= IOPWR_RST;
    end
    else if (ce)
    begin
      if (!pinRstN)
      begin
        cmdPending <= 1'b0;
        funcCtl    <= FUNC_RST;
        ifcCtl     <= IFC_RST;
        accCtl     <= ACC_RST;
        intEn      <= INTEN_RST;
        ioPwr      <= IOPWR_RST;
      end
      else
      begin
        cmdPending <= cmdSeen;
        if (cmdSeen)
          cmdAddr <= ulpi.bus[5:0];
        if (wrFunc)
          funcCtl <= ulpi.bus;
        if (wrAcc)
          accCtl <= ulpi.bus;
        if (wrIntEn)
          intEn <= ulpi.bus;
        if (wrIoPwr)
          ioPwr <= ulpi.bus;
        if (wrIfc)
          ifcCtl <= ulpi.bus;
        else if (exitReq)
          ifcCtl[IFC_ACC:IFC_SER6] <= 3'h0;
      end
    end
  end

  // Entry, alternate operation and exit sequencing
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state        <= PS_SYNC;
      cnt          <= 4'h0;
      modeQ        <= 3'h0;
      capt         <= '0;
      ulpi.dir     <= 1'b0;
      ulpiClockRun <= 1'b1;
    end
    else if (ce)
    begin
      if (!pinRstN)
      begin
        state        <= PS_SYNC;
        ulpi.dir     <= 1'b0;
        ulpiClockRun <= 1'b1;
      end
      else
      begin
        unique case (state)
          PS_SYNC:
          begin
            cnt <= 4'h0;
            if (|modeReq && !cmdPending)
            begin
              state <= PS_ENTER;
              modeQ <= modeReq;
            end
          end
          PS_ENTER:
          begin
            cnt <= cnt + 4'h1;
            if (entryEnd)
            begin
              state        <= PS_ALT;
              capt         <= srcLive;
              ulpi.dir     <= 1'b1;
              ulpiClockRun <= ifcCtl[IFC_KEEP];
            end
          end
          PS_ALT:
          begin
            if (ulpi.stp)
            begin
              state        <= PS_EXIT;
              ulpi.dir     <= 1'b0;
              ulpiClockRun <= 1'b1;
            end
          end
          PS_EXIT:
          begin
            if (!ulpi.stp)
              state <= PS_SYNC;
          end
        endcase
      end
    end
  end

  // Bus drive and USB-side outputs
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ulpi.phyDo          <= 8'h00;
      ulpi.phyOe          <= 8'h00;
      lineTxEn            <= 1'b0;
      lineTxData          <= 1'b0;
      singleEndedZeroLine <= 1'b0;
      uartMinus           <= 1'b1;
      regUart             <= 1'b0;
      pullupsOn           <= 1'b0;
      audioLeft           <= 1'b0;
      audioRight          <= 1'b0;
      edgeSelect          <= 2'h0;
      operating_mode_field              <= 2'h0;
      regLevel            <= 2'h0;
    end
    else if (ce)
    begin
      ulpi.phyDo          <= next_do;
      ulpi.phyOe          <= next_oe;
      lineTxEn            <= txGate;
      lineTxData          <= txGate & ulpi.bus[1];
      singleEndedZeroLine <= txGate & ulpi.bus[2];
      uartMinus           <= (inAlt & accMode & accCtl[ACC_TXD]) ? gate : 1'b1;
      regUart             <= inAlt & accMode & uartOn;
      pullupsOn           <= inAlt & accMode & uartOn;
      audioLeft           <= accCtl[ACC_LEFT];
      audioRight          <= accCtl[ACC_RIGHT];
      edgeSelect          <= funcCtl[FUNC_XCVR +: 2];
      operating_mode_field              <= funcCtl[FUNC_OPM +: 2];
      regLevel            <= ioPwr[IOPWR_UREG +: 2];
    end
  end
endmodule : ulpam_phy_end
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for both alternate-mode ULPI ends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ulpam_pkg::*;
  logic            refClk   = 1'b0;
  logic            nrst     = 1'b0;
  logic [3:0]      swAddr   = 4'h0;
  logic [7:0]      swWdata  = 8'h00;
  logic            swWr     = 1'b0;
  logic            swRd     = 1'b0;
  logic [7:0]      swRdata;
  logic            rxDiff   = 1'b0;
  logic            plusLvl  = 1'b0;
  logic            minusLvl = 1'b0;
  logic            rxZero   = 1'b0;
  logic [NSRC-1:0] intSrc   = '0;
  logic            lineTxEn, lineTxData, zeroLine, uartMinus, regUart, pullupsOn;
  logic            audioLeft, audioRight, clkRun;
  logic [1:0]      edgeSel, operating_mode_field, regLevel;
  int              nFail       = 0;
  int              totalChecks = 0;

  always #5 refClk = ~refClk;

  ulpam_if ulpi ();
  ulpam_phy_end u_ulpam_phy_end (.ref_clk(refClk), .nrst(nrst), .ce(1'b1), .ulpi(ulpi), .rxDiff(rxDiff),
    .receivePlusLevel(plusLvl), .receiveMinusLevel(minusLvl), .rxZero(rxZero), .intSrc(intSrc),
    .lineTxEn(lineTxEn), .lineTxData(lineTxData), .singleEndedZeroLine(zeroLine), .uartMinus(uartMinus),
    .regUart(regUart), .pullupsOn(pullupsOn), .audioLeft(audioLeft), .audioRight(audioRight),
    .ulpiClockRun(clkRun), .edgeSelect(edgeSel), .operating_mode_field(operating_mode_field), .regLevel(regLevel));
  ulpam_link_end u_ulpam_link_end (.ref_clk(refClk), .nrst(nrst), .ce(1'b1), .ulpi(ulpi), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
  ulpam_bus_monitor u_ulpam_bus_monitor (.ref_clk(refClk), .nrst(nrst), .linkOe(ulpi.linkOe),
    .phyDo(ulpi.phyDo), .phyOe(ulpi.phyOe), .bus(ulpi.bus), .dir(ulpi.dir), .stp(ulpi.stp),
    .resetPinN(ulpi.resetPinN));

  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finishTest

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge refClk);
    #1;
  endtask : tick

  task automatic swWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge refClk);
    swWr    <= 1'b1;
    swAddr  <= a;
    swWdata <= d;
    @(posedge refClk);
    swWr    <= 1'b0;
  endtask : swWrite

  task automatic swRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge refClk);
    swRd   <= 1'b1;
    swAddr <= a;
    @(posedge refClk);
    swRd   <= 1'b0;
    #1;
    d = swRdata;
  endtask : swRead

  // Register write over the bus, then wait until the sequencer is idle
  task automatic ulpiWr(input logic [5:0] r, input logic [7:0] v);
    logic [7:0] s;
    int         i;
    swWrite(SW_ADDR, {2'h0, r});
    swWrite(SW_DATA, v);
    s = 8'h08;
    for (i = 0; i < 20 && s[3]; i++)
      swRead(SW_STAT, s);
  endtask : ulpiWr

  task automatic waitDir(input logic v);
    int i;
    for (i = 0; i < 40 && ulpi.dir !== v; i++)
      tick(1);
    check("dir", {7'h0, ulpi.dir}, {7'h0, v});
    tick(3);
  endtask : waitDir

  task automatic exitAlt();
    swWrite(SW_CTL, 8'h01);
    waitDir(1'b0);
  endtask : exitAlt

  initial
  begin
    #500000;
    nFail = nFail + 1;
    finishTest();
  end

  initial
  begin
    repeat (8) @(posedge refClk);
    nrst <= 1'b1;
    tick(3);
    check("resetDir", {6'h0, ulpi.dir, clkRun}, 8'h01);
    // UART entry with one enabled interrupt source
    ulpiWr(REG_INTEN, 8'h01);
    ulpiWr(REG_FUNC, 8'h49);
    ulpiWr(REG_IOPWR, 8'h00);
    ulpiWr(REG_ACC, 8'h0c);
    ulpiWr(REG_IFC, 8'h04);
    check("edgeSel", {6'h0, edgeSel}, 8'h01);
    check("operating_mode_field", {6'h0, operating_mode_field}, 8'h01);
    waitDir(1'b1);
    check("clkStop", {7'h0, clkRun}, 8'h00);
    check("uartPower", {4'h0, regLevel, pullupsOn, regUart}, 8'h03);
    tick(3);
    check("txdLow", {7'h0, uartMinus}, 8'h00);
    swWrite(SW_CTL, 8'h20);
    tick(4);
    check("txdHigh", {7'h0, uartMinus}, 8'h01);
    @(posedge refClk);
    plusLvl <= 1'b1;
    tick(6);
    check("rxd", {7'h0, ulpi.bus[1]}, 8'h01);
    check("accLow", {ulpi.bus[7:4], 1'b0, ulpi.bus[2], 2'h0}, 8'h00);
    @(posedge refClk);
    intSrc <= 4'h2;
    tick(6);
    check("intMasked", {7'h0, ulpi.bus[3]}, 8'h00);
    @(posedge refClk);
    intSrc <= 4'h3;
    tick(6);
    check("intSet", {7'h0, ulpi.bus[3]}, 8'h01);
    @(posedge refClk);
    intSrc <= 4'h2;
    tick(6);
    check("intBack", {7'h0, ulpi.bus[3]}, 8'h00);
    exitAlt();
    // 3-pin serial with the clock kept running
    ulpiWr(REG_IFC, 8'h0a);
    waitDir(1'b1);
    check("clkKeep", {7'h0, clkRun}, 8'h01);
    @(posedge refClk);
    rxDiff <= 1'b1;
    tick(6);
    check("ser3Rx", ulpi.bus & 8'hf6, 8'h06);
    swWrite(SW_CTL, 8'h0c);
    tick(4);
    check("ser3Tx", {5'h0, lineTxEn, lineTxData, zeroLine}, 8'h06);
    exitAlt();
    // 6-pin serial
    ulpiWr(REG_IFC, 8'h01);
    waitDir(1'b1);
    tick(3);
    check("ser6Rx", {4'h0, ulpi.bus[7:4]}, 8'h05);
    swWrite(SW_CTL, 8'h14);
    tick(4);
    check("ser6Tx", {5'h0, lineTxEn, lineTxData, zeroLine}, 8'h05);
    swWrite(SW_CTL, 8'h10);
    tick(4);
    check("ser6Gate", {7'h0, lineTxEn}, 8'h00);
    exitAlt();
    // Audio entry, then reset pin pulse
    ulpiWr(REG_FUNC, 8'h48);
    ulpiWr(REG_ACC, 8'h30);
    check("audioOn", {6'h0, audioLeft, audioRight}, 8'h03);
    ulpiWr(REG_IFC, 8'h04);
    waitDir(1'b1);
    check("audioAcc", {6'h0, audioLeft, clkRun}, 8'h02);
    swWrite(SW_CTL, 8'h02);
    tick(12);
    check("pinReset", {5'h0, ulpi.dir, audioLeft, clkRun}, 8'h01);
    finishTest();
  end
endmodule : tb_top
`default_nettype wire

//--- verif/ulpam_bus_monitor.sv
// Protocol checker on the shared ULPI bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module ulpam_bus_monitor (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [7:0] linkOe,
  input wire logic [7:0] phyDo,
  input wire logic [7:0] phyOe,
  input wire logic [7:0] bus,
  input wire logic       dir,
  input wire logic       stp,
  input wire logic       resetPinN
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  chk_exit_dir_drop: assert property (dir && stp |=> !dir)
    else $error("dir still high after stop seen");
  chk_stp_release: assert property ($fell(dir) && stp |-> ##2 !stp)
    else $error("stop not released after dir low");
  chk_dir_hold: assert property (dir && !stp && resetPinN |=> dir)
    else $error("dir dropped without stop");
  chk_oe_needs_dir: assert property (phyOe != 8'h00 |-> dir)
    else $error("device drives bus without dir");
  chk_format_after_dir: assert property ($rose(dir) |=> phyOe != 8'h00)
    else $error("no alternate format after dir");
  chk_entry_delay: assert property ($rose(dir) |-> !$past(stp, 1) && !$past(stp, 2)
    && !$past(stp, 3) && !$past(stp, 4))
    else $error("dir raised too soon after write");
  chk_int_bit_driven: assert property (dir && $past(dir) && resetPinN |-> phyOe[3])
    else $error("interrupt bit not driven");
  chk_top_bit_low: assert property (dir && $past(dir) && resetPinN |-> phyOe[7] && !phyDo[7] && !bus[7])
    else $error("bit 7 not driven low");
  chk_link_bits_quiet: assert property (dir && $past(dir) |-> linkOe[7:3] == 5'h00)
    else $error("link drives device-owned bits");
  chk_pin_reset_sync: assert property (!resetPinN [*4] |-> !dir && phyOe == 8'h00)
    else $error("reset pin did not restore sync mode");
endmodule : ulpam_bus_monitor
`default_nettype wire
